// >>> rmcrx_defs.svh
`ifndef RMCRX_DEFS_SVH
`define RMCRX_DEFS_SVH
// Overview of operation
// - status bit 15 marks leader interrupt
// - status bit 14 marks excess low width
// - status bit 13 marks maximum bit cycle
// - status bit 12 marks falling edge interrupt
// - status bit 7 set on leader
// - seven bit count, saturating at 127
// - count loaded only at reception end
// - status refreshed per interrupt, writes ignored
// - keep receiving past 72 bits
// - input sampled at 32.768 kHz
// - leader interrupt only when enabled
// - classify data bits into three buffers
// - edge interrupt per data falling edge
// - max cycle or low width ends reception
// - return to leader wait after completion
// - leaderless mode starts without a leader
// - new result overwrites unread result
// - level change after programmed opposite samples
// - leader checked against four 8-bit bounds
// - no leader interrupt without a leader
// - filter setting zero disables cancellation
// - input polarity bit inverts input
// - no edge within threshold ends reception
// - low too long after edge ends reception

// timing
`define RMCRX_CLK_HZ 125000000
`define RMCRX_SAMPLE_HZ 32768
`define RMCRX_SAMPLE_DIV ((`RMCRX_CLK_HZ + `RMCRX_SAMPLE_HZ / 2) / `RMCRX_SAMPLE_HZ)
`define RMCRX_DIV_W 12
`define RMCRX_DIV_MIN 3
`define RMCRX_DIV_MAX 4096
// sizes
`define RMCRX_MAX_BITS 72
`define RMCRX_CNT_W 7
`define RMCRX_CNT_MAX 7'h7F
`define RMCRX_W_MAX 8'hFF
`define RMCRX_ADDR_W 8
`define RMCRX_IDLE_LEVEL 1'b1
// register offsets
`define RMCRX_OFS_ENABLE 8'h00
`define RMCRX_OFS_LEADER 8'h04
`define RMCRX_OFS_TWO 8'h08
`define RMCRX_OFS_THR 8'h0C
`define RMCRX_OFS_INPUT 8'h10
`define RMCRX_OFS_STATUS 8'h14
`define RMCRX_OFS_BUF1 8'h18
`define RMCRX_OFS_BUF2 8'h1C
`define RMCRX_OFS_BUF3 8'h20
// writable masks
`define RMCRX_ENABLE_MASK 32'h0000_0001
`define RMCRX_TWO_MASK 32'h0007_FFFF
`define RMCRX_THR_MASK 32'h0000_007F
`define RMCRX_INPUT_MASK 32'h0000_008F
// fields
`define RMCRX_EN_BIT 0
`define RMCRX_LC_LLMIN 7:0
`define RMCRX_LC_LLMAX 15:8
`define RMCRX_LC_LCMIN 23:16
`define RMCRX_LC_LCMAX 31:24
`define RMCRX_TWO_DMAX 7:0
`define RMCRX_TWO_LL 15:8
`define RMCRX_TWO_LDEN 16
`define RMCRX_TWO_EDIEN 17
`define RMCRX_TWO_LIEN 18
`define RMCRX_THR_VAL 6:0
`define RMCRX_IN_INV 7
`define RMCRX_IN_NC 3:0
`define RMCRX_ST_LIF 15
`define RMCRX_ST_LOIF 14
`define RMCRX_ST_MAXIF 13
`define RMCRX_ST_EDIF 12
`define RMCRX_ST_LDR 7
`define RMCRX_ST_NUM 6:0
`define RMCRX_BUF1 31:0
`define RMCRX_BUF2 63:32
`define RMCRX_BUF3 71:64
// flag codes, order lif loif maxif edif
`define RMCRX_FLAG_LEADER 4'h8
`define RMCRX_FLAG_LOW 4'h4
`define RMCRX_FLAG_MAX 4'h2
`define RMCRX_FLAG_EDGE 4'h1
// responses
`define RMCRX_RESP_OKAY 2'h0
`define RMCRX_RESP_SLVERR 2'h2
`endif

// >>> rmcrx_filter.sv
`timescale 1ns/10ps
module rmcrx_filter
  import rmcrx_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampling
  input wire logic tick,
  input wire logic din,
  input wire logic [3:0] nc,
  // filtered level
  output logic level
);
  rmcrx_filt_t r_reg;
  rmcrx_filt_t r_next;

  // count opposite samples before accepting a change
  always_comb begin
    r_next = r_reg;
    if (tick) begin
      if (nc == 4'h0) begin
        r_next.level = din;
        r_next.cnt = 4'h0;
      end else if (din != r_reg.level) begin
        if (r_reg.cnt + 4'h1 == nc) begin
          r_next.level = din;
          r_next.cnt = 4'h0;
        end else begin
          r_next.cnt = r_reg.cnt + 4'h1;
        end
      end else begin
        r_next.cnt = 4'h0;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg.level <= `RMCRX_IDLE_LEVEL;
      r_reg.cnt <= 4'h0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.level;
endmodule : rmcrx_filter

// >>> rmcrx_pkg.sv
`include "rmcrx_defs.svh"
package rmcrx_pkg;
  typedef enum logic [1:0] {RMCRX_OFF, RMCRX_WAIT, RMCRX_RECV} rmcrx_state_t;

  typedef struct packed {
    logic level;
    logic [3:0] cnt;
  } rmcrx_filt_t;

  typedef struct packed {
    rmcrx_state_t st;
    logic [`RMCRX_DIV_W-1:0] div;
    logic tick;
    logic tick_d;
    logic fprev;
    logic armed;
    logic [7:0] cyc;
    logic [7:0] low;
    logic [7:0] lowlen;
    logic [`RMCRX_CNT_W-1:0] cnt;
    logic [`RMCRX_MAX_BITS-1:0] work;
    logic [`RMCRX_MAX_BITS-1:0] bufv;
    logic [3:0] flags;
    logic leader_seen;
    logic [`RMCRX_CNT_W-1:0] count;
    logic irq;
    logic [31:0] cfg_en;
    logic [31:0] cfg_lead;
    logic [31:0] cfg_two;
    logic [31:0] cfg_thr;
    logic [31:0] cfg_in;
    logic aw_got;
    logic [`RMCRX_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rmcrx_regs_t;
endpackage : rmcrx_pkg

// >>> rmcrx_remote.sv
`timescale 1ns/10ps
module rmcrx_remote #(
  parameter int TICK = 4
) (
  // clock
  input wire logic aclk,
  // line to the receiver, idles high
  output logic rc_line
);
  initial rc_line = 1'b1;

  // drive one level for n sample ticks
  task automatic hold(input logic lv, input int n);
    rc_line <= lv;
    repeat (n * TICK) @(posedge aclk);
  endtask : hold

  // leader shape, bits lsb first, then a tail that ends the frame
  task automatic frame(input logic [31:0] pat, input int nb, input bit low_end, input bit glitch);
    hold(1'b0, 10);
    hold(1'b1, 8);
    for (int i = 0; i < nb; i++) begin
      hold(1'b0, 4);
      if (!pat[i % 32]) begin
        hold(1'b1, 3);
      end else if (glitch) begin
        hold(1'b1, 3);
        hold(1'b0, 1); // short spike the filter must swallow
        hold(1'b1, 4);
      end else begin
        hold(1'b1, 8);
      end
    end
    hold(1'b0, low_end ? 14 : 4);
    hold(1'b1, 30);
  endtask : frame
endmodule : rmcrx_remote

// >>> rmcrx_top.sv
`timescale 1ns/10ps
module rmcrx_top
  import rmcrx_pkg::*;
#(
  parameter int SAMPLE_DIV = `RMCRX_SAMPLE_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // remote control input
  input wire logic rc_in,
  // write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`RMCRX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`RMCRX_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // event pulse
  output logic irq_pulse
);
  localparam logic [`RMCRX_DIV_W-1:0] DIV_LAST = `RMCRX_DIV_W'(SAMPLE_DIV - 1);

  // refuse dividers the counter cannot hold or the pipeline cannot follow
  if (SAMPLE_DIV < `RMCRX_DIV_MIN || SAMPLE_DIV > `RMCRX_DIV_MAX) begin : g_chk
    $error("rmcrx_top: SAMPLE_DIV out of range");
  end

  rmcrx_regs_t r_reg;
  rmcrx_regs_t r_next;
  logic flt_level;
  logic [31:0] status_w;
  logic ev_leader;
  logic ev_ll;
  logic ev_edge;
  logic ev_max;
  logic ev_low;
  logic wr_fire;

  // saturating width counter step
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == `RMCRX_W_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  // leader window check, zero low maximum skips the low part, zero cycle maximum fails the match
  function automatic logic leader_match(input logic [7:0] cyc, input logic [7:0] low, input logic [31:0] c);
    logic cyc_ok;
    logic low_ok;
    cyc_ok = (c[`RMCRX_LC_LCMAX] != 8'h00) && (cyc >= c[`RMCRX_LC_LCMIN]) && (cyc <= c[`RMCRX_LC_LCMAX]);
    low_ok = (c[`RMCRX_LC_LLMAX] == 8'h00) || ((low >= c[`RMCRX_LC_LLMIN]) && (low <= c[`RMCRX_LC_LLMAX]));
    return cyc_ok && low_ok;
  endfunction : leader_match

  // address map hit, shared by read and write paths
  function automatic logic addr_hit(input logic [`RMCRX_ADDR_W-1:0] a);
    logic [`RMCRX_ADDR_W-1:0] w;
    w = {a[`RMCRX_ADDR_W-1:2], 2'b00};
    return (w == `RMCRX_OFS_ENABLE) || (w == `RMCRX_OFS_LEADER) || (w == `RMCRX_OFS_TWO) ||
           (w == `RMCRX_OFS_THR) || (w == `RMCRX_OFS_INPUT) || (w == `RMCRX_OFS_STATUS) ||
           (w == `RMCRX_OFS_BUF1) || (w == `RMCRX_OFS_BUF2) || (w == `RMCRX_OFS_BUF3);
  endfunction : addr_hit

  // byte lane merge for configuration writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction : wmerge

  // glitch filter on the polarity-corrected sample
  rmcrx_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(r_reg.tick),
    .din(rc_in ^ r_reg.cfg_in[`RMCRX_IN_INV]),
    .nc(r_reg.cfg_in[`RMCRX_IN_NC]),
    .level(flt_level)
  );

  // status word, unassigned bits tied low
  assign status_w = {16'h0000, r_reg.flags, 4'h0, r_reg.leader_seen, r_reg.count};
  assign wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;

  // next state
  always_comb begin
    logic fall;
    logic rise;
    logic [7:0] cyc_n;
    logic [7:0] low_n;
    logic [`RMCRX_ADDR_W-1:0] wa;
    logic [`RMCRX_ADDR_W-1:0] ra;
    fall = 1'b0;
    rise = 1'b0;
    cyc_n = 8'h00;
    low_n = 8'h00;
    wa = 8'h00;
    ra = 8'h00;
    ev_leader = 1'b0;
    ev_ll = 1'b0;
    ev_edge = 1'b0;
    ev_max = 1'b0;
    ev_low = 1'b0;
    r_next = r_reg;
    r_next.irq = 1'b0;

    // sampling clock enable
    r_next.tick = 1'b0;
    r_next.tick_d = r_reg.tick;
    if (r_reg.div == DIV_LAST) begin
      r_next.div = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.div = r_reg.div + `RMCRX_DIV_W'(1);
    end

    // edge and width measurement, one clock after the filter moves
    if (r_reg.tick_d) begin
      fall = r_reg.fprev && !flt_level;
      rise = !r_reg.fprev && flt_level;
      cyc_n = sat_inc(r_reg.cyc);
      low_n = sat_inc(r_reg.low);
      r_next.fprev = flt_level;
      if (fall) begin
        r_next.cyc = 8'h00;
        r_next.low = 8'h00;
      end else begin
        r_next.cyc = cyc_n;
        if (!flt_level) begin
          r_next.low = low_n;
        end
      end
      if (rise) begin
        r_next.lowlen = r_reg.low;
      end

      unique case (r_reg.st)
        RMCRX_OFF: begin
        end
        RMCRX_WAIT: begin
          if (fall) begin
            if (r_reg.armed && leader_match(cyc_n, r_reg.lowlen, r_reg.cfg_lead)) begin
              ev_leader = 1'b1;
            end else if (r_reg.cfg_two[`RMCRX_TWO_LDEN]) begin
              ev_ll = 1'b1;
            end
            r_next.armed = 1'b1;
          end
        end
        RMCRX_RECV: begin
          if (fall) begin
            ev_edge = 1'b1;
          end else if ((r_reg.cfg_two[`RMCRX_TWO_DMAX] != 8'h00) && (cyc_n >= r_reg.cfg_two[`RMCRX_TWO_DMAX])) begin
            ev_max = 1'b1;
          end else if (!flt_level && (r_reg.cfg_two[`RMCRX_TWO_LL] != 8'h00) &&
                       (low_n > r_reg.cfg_two[`RMCRX_TWO_LL])) begin
            ev_low = 1'b1;
          end
        end
      endcase
    end

    // start of reception, with or without a leader
    if (ev_leader || ev_ll) begin
      r_next.st = RMCRX_RECV;
      r_next.cnt = '0;
      r_next.work = '0;
      r_next.leader_seen = ev_leader;
    end
    if (ev_leader && r_reg.cfg_two[`RMCRX_TWO_LIEN]) begin
      r_next.flags = `RMCRX_FLAG_LEADER;
      r_next.irq = 1'b1;
    end

    // data bit classification and storage
    if (ev_edge) begin
      if (r_reg.cnt < `RMCRX_CNT_W'(`RMCRX_MAX_BITS)) begin
        r_next.work[r_reg.cnt] = (cyc_n >= {1'b0, r_reg.cfg_thr[`RMCRX_THR_VAL]});
      end
      if (r_reg.cnt != `RMCRX_CNT_MAX) begin
        r_next.cnt = r_reg.cnt + `RMCRX_CNT_W'(1);
      end
      if (r_reg.cfg_two[`RMCRX_TWO_EDIEN]) begin
        r_next.flags = `RMCRX_FLAG_EDGE;
        r_next.irq = 1'b1;
      end
    end

    // completion, first detected factor wins
    if (ev_max || ev_low) begin
      r_next.st = RMCRX_WAIT;
      r_next.armed = 1'b0;
      r_next.count = r_reg.cnt;
      r_next.bufv = r_reg.work;
      r_next.flags = ev_max ? `RMCRX_FLAG_MAX : `RMCRX_FLAG_LOW;
      r_next.irq = 1'b1;
    end

    // receiver enable, clearing drops the frame in flight
    if (!r_reg.cfg_en[`RMCRX_EN_BIT]) begin
      r_next.st = RMCRX_OFF;
      r_next.armed = 1'b0;
    end else if (r_reg.st == RMCRX_OFF) begin
      r_next.st = RMCRX_WAIT;
    end

    // write response retire
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // write execute once address and data are both held
    if (wr_fire) begin
      wa = {r_reg.aw_addr[`RMCRX_ADDR_W-1:2], 2'b00};
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_hit(r_reg.aw_addr) ? `RMCRX_RESP_OKAY : `RMCRX_RESP_SLVERR;
      if (wa == `RMCRX_OFS_ENABLE) begin
        r_next.cfg_en = wmerge(r_reg.cfg_en, r_reg.wdata, r_reg.wstrb) & `RMCRX_ENABLE_MASK;
      end else if (wa == `RMCRX_OFS_LEADER) begin
        r_next.cfg_lead = wmerge(r_reg.cfg_lead, r_reg.wdata, r_reg.wstrb);
      end else if (wa == `RMCRX_OFS_TWO) begin
        r_next.cfg_two = wmerge(r_reg.cfg_two, r_reg.wdata, r_reg.wstrb) & `RMCRX_TWO_MASK;
      end else if (wa == `RMCRX_OFS_THR) begin
        r_next.cfg_thr = wmerge(r_reg.cfg_thr, r_reg.wdata, r_reg.wstrb) & `RMCRX_THR_MASK;
      end else if (wa == `RMCRX_OFS_INPUT) begin
        r_next.cfg_in = wmerge(r_reg.cfg_in, r_reg.wdata, r_reg.wstrb) & `RMCRX_INPUT_MASK;
      end
      // status and buffers take no writes
    end

    // capture write address and data in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;

    // read channel, one outstanding
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      ra = {s_axi_araddr[`RMCRX_ADDR_W-1:2], 2'b00};
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_hit(s_axi_araddr) ? `RMCRX_RESP_OKAY : `RMCRX_RESP_SLVERR;
      unique case (ra)
        `RMCRX_OFS_ENABLE: r_next.rdata = r_reg.cfg_en;
        `RMCRX_OFS_LEADER: r_next.rdata = r_reg.cfg_lead;
        `RMCRX_OFS_TWO: r_next.rdata = r_reg.cfg_two;
        `RMCRX_OFS_THR: r_next.rdata = r_reg.cfg_thr;
        `RMCRX_OFS_INPUT: r_next.rdata = r_reg.cfg_in;
        `RMCRX_OFS_STATUS: r_next.rdata = status_w;
        `RMCRX_OFS_BUF1: r_next.rdata = r_reg.bufv[`RMCRX_BUF1];
        `RMCRX_OFS_BUF2: r_next.rdata = r_reg.bufv[`RMCRX_BUF2];
        `RMCRX_OFS_BUF3: r_next.rdata = {24'h00_0000, r_reg.bufv[`RMCRX_BUF3]};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    r_next.arready = !r_next.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.st <= RMCRX_OFF;
      r_reg.fprev <= `RMCRX_IDLE_LEVEL;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign irq_pulse = r_reg.irq;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_tick_spacing;
    r_reg.tick |=> !r_reg.tick [*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sample tick too frequent");

  property p_leader_flag;
    ev_leader && r_reg.cfg_two[`RMCRX_TWO_LIEN] |=> status_w[`RMCRX_ST_LIF] && status_w[`RMCRX_ST_LDR] && irq_pulse;
  endproperty
  a_leader_flag: assert property (p_leader_flag) else $error("leader flag missing");

  property p_low_done;
    ev_low |=> status_w[`RMCRX_ST_LOIF] && !status_w[`RMCRX_ST_MAXIF] && (r_reg.st == RMCRX_WAIT);
  endproperty
  a_low_done: assert property (p_low_done) else $error("low width completion wrong");

  property p_max_done;
    ev_max |=> status_w[`RMCRX_ST_MAXIF] && (status_w[`RMCRX_ST_NUM] == $past(r_reg.cnt)) && (r_reg.bufv == $past(r_reg.work));
  endproperty
  a_max_done: assert property (p_max_done) else $error("max cycle completion wrong");

  property p_edge_flag;
    ev_edge && r_reg.cfg_two[`RMCRX_TWO_EDIEN] && !ev_max |=> status_w[`RMCRX_ST_EDIF] && irq_pulse;
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag missing");

  property p_leaderless;
    ev_ll |=> !status_w[`RMCRX_ST_LIF] && !status_w[`RMCRX_ST_LDR] && (r_reg.st == RMCRX_RECV);
  endproperty
  a_leaderless: assert property (p_leaderless) else $error("leaderless start raised leader flag");

  property p_count_hidden;
    (r_reg.st == RMCRX_RECV) && !ev_max && !ev_low |=> $stable(status_w[`RMCRX_ST_NUM]);
  endproperty
  a_count_hidden: assert property (p_count_hidden) else $error("count moved during reception");

  property p_status_ro;
    wr_fire && ({r_reg.aw_addr[`RMCRX_ADDR_W-1:2], 2'b00} == `RMCRX_OFS_STATUS) && !r_next.irq &&
      !ev_leader && !ev_ll |=> $stable(status_w);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_status_read;
    s_axi_arvalid && s_axi_arready && ({s_axi_araddr[`RMCRX_ADDR_W-1:2], 2'b00} == `RMCRX_OFS_STATUS)
      |=> s_axi_rvalid && (s_axi_rdata == $past(status_w)) && (s_axi_rdata[31:16] == 16'h0000);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule : rmcrx_top

// >>> tb_rmcrx_top.sv
`timescale 1ns/10ps
`include "rmcrx_defs.svh"
module tb_rmcrx_top;
  typedef struct {logic [31:0] pat; int nb; bit low_end;} rmcrx_row_t;
  rmcrx_row_t rows [4] = '{'{32'h0000_00A5, 8, 1'b0}, '{32'h0000_0001, 1, 1'b1},
                           '{32'h0000_0000, 0, 1'b0}, '{32'hDEAD_BEEF, 32, 1'b1}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic inv = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [1:0] rsp;
  wire logic awready, wready, bvalid, arready, rvalid, irq_pulse, rc_line;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int fail_count = 0;
  int n_tests = 0;
  int n_irq = 0;

  // receiver with a fast sample tick
  rmcrx_top #(.SAMPLE_DIV(4)) rmcrx_top_inst (
    .aclk(aclk), .aresetn(aresetn), .rc_in(rc_line ^ inv),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq_pulse(irq_pulse));

  // far-side transmitter
  rmcrx_remote #(.TICK(4)) rmcrx_remote_inst (.aclk(aclk), .rc_line(rc_line));

  // 125 MHz clock
  initial begin
    forever #4 aclk = ~aclk;
  end

  // event pulse counter
  always @(posedge aclk) begin
    if (irq_pulse === 1'b1) n_irq <= n_irq + 1;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bus write: address and data offered together, response awaited
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 200);
    rsp = bresp;
    bready <= 1'b0;
    if (k >= 200) begin
      fail_count++;
      print_verdict();
    end
  endtask : axw

  // bus read
  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 200);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (k >= 200) begin
      fail_count++;
      print_verdict();
    end
  endtask : axr

  // overall hang guard
  initial begin
    repeat (100000) @(posedge aclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] m;
    int irq_base;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`RMCRX_OFS_STATUS);
    chk("status_reset", rd, 32'h0000_0000);
    axr(`RMCRX_OFS_TWO);
    chk("two_reset", rd, 32'h0000_0000);
    axw(`RMCRX_OFS_LEADER, 32'h180F_0C08);
    axw(`RMCRX_OFS_TWO, 32'h0000_0814);
    axw(`RMCRX_OFS_THR, 32'h0000_000A);
    axw(`RMCRX_OFS_ENABLE, 32'h0000_0001);
    $display("test reset done");
    // ordinary frames, each ending one way or the other
    foreach (rows[r]) begin
      rmcrx_remote_inst.frame(rows[r].pat, rows[r].nb, rows[r].low_end, 1'b0);
      m = (rows[r].nb >= 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << rows[r].nb) - 32'h0000_0001);
      axr(`RMCRX_OFS_STATUS);
      chk("status", rd, {16'h0000, rows[r].low_end ? 4'h4 : 4'h2, 4'h0, 1'b1, 7'(rows[r].nb)});
      axr(`RMCRX_OFS_BUF1);
      chk("buf1", rd, rows[r].pat & m);
      axr(`RMCRX_OFS_BUF2);
      chk("buf2", rd, 32'h0000_0000);
    end
    $display("test rows done");
    axw(`RMCRX_OFS_STATUS, 32'hFFFF_FFFF);
    chk("bresp_status", 32'(rsp), 32'h0000_0000);
    axr(`RMCRX_OFS_STATUS);
    chk("status_written", rd, 32'h0000_40A0);
    axr(8'h40);
    chk("rresp_unmapped", 32'(rsp), 32'h0000_0002);
    chk("rdata_unmapped", rd, 32'h0000_0000);
    axw(`RMCRX_OFS_TWO, 32'hFFFF_FFFF);
    axr(`RMCRX_OFS_TWO);
    chk("two_mask", rd, 32'h0007_FFFF);
    $display("test bus done");
    // events while a frame is under way
    axw(`RMCRX_OFS_TWO, 32'h0006_0814);
    irq_base = n_irq;
    fork
      rmcrx_remote_inst.frame(32'h0000_00C3, 8, 1'b0, 1'b0);
      begin
        repeat (86) @(posedge aclk);
        axr(`RMCRX_OFS_STATUS);
        chk("status_leader", rd, 32'h0000_80A0);
        repeat (46) @(posedge aclk);
        axr(`RMCRX_OFS_STATUS);
        chk("status_edge", rd, 32'h0000_10A0);
      end
    join
    axr(`RMCRX_OFS_STATUS);
    chk("status_events", rd, 32'h0000_2088);
    chk("event_count", 32'(n_irq - irq_base), 32'h0000_000A);
    $display("test events done");
    // spikes shorter than the filter setting
    axw(`RMCRX_OFS_TWO, 32'h0000_0814);
    axw(`RMCRX_OFS_INPUT, 32'h0000_0003);
    rmcrx_remote_inst.frame(32'h0000_00B6, 8, 1'b0, 1'b1);
    axr(`RMCRX_OFS_STATUS);
    chk("status_filter", rd, 32'h0000_2088);
    axr(`RMCRX_OFS_BUF1);
    chk("buf1_filter", rd, 32'h0000_00B6);
    $display("test filter done");
    // inverted line
    inv <= 1'b1;
    axw(`RMCRX_OFS_INPUT, 32'h0000_0080);
    rmcrx_remote_inst.frame(32'h0000_005A, 8, 1'b1, 1'b0);
    axr(`RMCRX_OFS_STATUS);
    chk("status_invert", rd, 32'h0000_4088);
    axr(`RMCRX_OFS_BUF1);
    chk("buf1_invert", rd, 32'h0000_005A);
    axw(`RMCRX_OFS_INPUT, 32'h0000_0000);
    inv <= 1'b0;
    $display("test invert done");
    // more than 72 bits
    rmcrx_remote_inst.frame(32'hFFFF_FFFF, 75, 1'b0, 1'b0);
    axr(`RMCRX_OFS_STATUS);
    chk("status_long", rd & 32'hFFFF_FF80, 32'h0000_2080);
    chk("count_long", 32'(rd[6:0] >= 7'h49), 32'h0000_0001);
    $display("test long done");
    // no leader, leaderless reception
    axw(`RMCRX_OFS_LEADER, 32'h000F_0C08);
    axw(`RMCRX_OFS_TWO, 32'h0001_0814);
    rmcrx_remote_inst.frame(32'h0000_0005, 4, 1'b0, 1'b0);
    axr(`RMCRX_OFS_STATUS);
    chk("status_noleader", rd & 32'h0000_F080, 32'h0000_2000);
    $display("test leaderless done");
    print_verdict();
  end
endmodule : tb_rmcrx_top
